//--- rtl/shadow_update_nvm_sequencer.sv
// shadow update, system alignment controls and nvm command segment walker
`timescale 1ns/1ps
`include "shadow_nvm_regs.svh"
module shadow_update_nvm_sequencer
   import shadow_nvm_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire reg_req_t            reg_req,
   output logic [`DATA_W-1:0]       reg_rdata,
   input  wire logic [`DATA_W-1:0]  buf_rdata,
   output buf_port_t                buf_port,
   output nvm_port_t                nvm_port,
   input  wire logic                nvm_ack,
   input  wire logic [`DATA_W-1:0]  nvm_rdata,
   output logic                     apply_shadow,
   output logic                     nvm_busy,
   output logic                     runt_suppress_en,
   output logic                     align_power_down,
   output logic                     dist_ref_power_down,
   output logic                     align_hold,
   output logic                     align_event
);

   // ==========================================================
   // default segment image
   function automatic logic [`DATA_W-1:0] seg_default(input int idx);
      logic [`ADDR_W-1:0] base;
      int                 chunk;
      chunk = idx / 3;
      base  = `ADDR_W'(chunk) * `SEG_DEF_STEP;
      if (chunk < `SEG_DEF_CHUNKS) begin
         case (idx % 3)
            0:       seg_default = `SEG_DEF_LEN;
            1:       seg_default = {4'h0, base[11:8]};
            default: seg_default = base[7:0];
         endcase
      end else if (idx == 3 * `SEG_DEF_CHUNKS) begin
         seg_default = `OP_APPLY;
      end else begin
         seg_default = `OP_END;
      end
   endfunction

   // ==========================================================
   // declarations
   logic [`DATA_W-1:0]  seg_mem [`SEG_DEPTH];
   align_ctrl_t         align_ctrl;
   logic                update_pending;
   logic                store_req;
   logic                load_req;
   align_ctrl_t         next_align_ctrl;
   logic                next_update_pending;
   logic                next_store_req;
   logic                next_load_req;
   logic [`DATA_W-1:0]  next_reg_rdata;

   walk_state_t         state;
   logic [`SEG_AW-1:0]  seg_ptr;
   logic [`LEN_W-1:0]   xfer_left;
   logic [`ADDR_W-1:0]  buf_addr;
   logic [`ADDR_W-1:0]  nvm_addr;
   logic [`DATA_W-1:0]  data_hold;
   logic                dir_store;
   logic                busy;
   logic                op_apply;
   walk_state_t         next_state;
   logic [`SEG_AW-1:0]  next_seg_ptr;
   logic [`LEN_W-1:0]   next_xfer_left;
   logic [`ADDR_W-1:0]  next_buf_addr;
   logic [`ADDR_W-1:0]  next_nvm_addr;
   logic [`DATA_W-1:0]  next_data_hold;
   logic                next_dir_store;
   logic                next_busy;
   logic                next_op_apply;

   logic [`DATA_W-1:0]  seg_byte;
   logic                seg_hit;
   logic [`SEG_AW-1:0]  seg_widx;
   logic                step;
   logic                finish;
   logic                wr_align;
   logic                wr_update;
   logic                wr_store;
   logic                wr_load;

   // ==========================================================
   // register decode
   assign seg_hit   = (reg_req.addr >= `OFF_SEG_BASE) && (reg_req.addr <= `OFF_SEG_LAST);
   assign seg_widx  = reg_req.addr[`SEG_AW-1:0];
   assign wr_align  = reg_req.wr && (reg_req.addr == `OFF_ALIGN_CTRL);
   assign wr_update = reg_req.wr && (reg_req.addr == `OFF_UPDATE);
   assign wr_store  = reg_req.wr && (reg_req.addr == `OFF_NVM_STORE);
   assign wr_load   = reg_req.wr && (reg_req.addr == `OFF_NVM_LOAD);
   assign seg_byte  = seg_mem[seg_ptr];

   // ==========================================================
   // command segment storage, host writable at any time
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < `SEG_DEPTH; i++) begin
            seg_mem[i] <= seg_default(i);
         end
      end else if (reg_req.wr && seg_hit) begin
         seg_mem[seg_widx] <= reg_req.wdata;
      end
   end

   // ==========================================================
   // control registers
   always_comb begin
      next_align_ctrl = align_ctrl;
      if (wr_align) begin
         next_align_ctrl = align_ctrl_t'(reg_req.wdata[3:0]);
      end
      // one-cycle request: copy happens on the following edge, then it is gone
      next_update_pending = wr_update && reg_req.wdata[`BIT_REQ];
      // a new request is refused while a walk runs, so the finish clear cannot eat it
      next_store_req = store_req;
      next_load_req  = load_req;
      if (finish) begin
         next_store_req = 1'b0;
         next_load_req  = 1'b0;
      end
      if (!busy && wr_store && reg_req.wdata[`BIT_REQ]) begin
         next_store_req = 1'b1;
      end
      if (!busy && wr_load && reg_req.wdata[`BIT_LOAD]) begin
         next_load_req = 1'b1;
      end
      next_reg_rdata = reg_rdata;
      if (reg_req.rd) begin
         next_reg_rdata = `BYTE_ZERO;
         if (seg_hit) begin
            next_reg_rdata = seg_mem[seg_widx];
         end else begin
            case (reg_req.addr)
               `OFF_ALIGN_CTRL: next_reg_rdata = {4'h0, align_ctrl};
               `OFF_UPDATE:     next_reg_rdata = {7'h00, update_pending};
               `OFF_NVM_STATUS: next_reg_rdata = {7'h00, busy};
               `OFF_NVM_LOAD:   next_reg_rdata = {6'h00, load_req, 1'b0};
               `OFF_NVM_STORE:  next_reg_rdata = {7'h00, store_req};
               default:         next_reg_rdata = `BYTE_ZERO;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         align_ctrl     <= align_ctrl_t'(`ALIGN_CTRL_RST);
         update_pending <= 1'b0;
         store_req      <= 1'b0;
         load_req       <= 1'b0;
         reg_rdata      <= `BYTE_ZERO;
      end else begin
         align_ctrl     <= next_align_ctrl;
         update_pending <= next_update_pending;
         store_req      <= next_store_req;
         load_req       <= next_load_req;
         reg_rdata      <= next_reg_rdata;
      end
   end

   // ==========================================================
   // segment walker
   always_comb begin
      next_state     = state;
      next_seg_ptr   = seg_ptr;
      next_xfer_left = xfer_left;
      next_buf_addr  = buf_addr;
      next_nvm_addr  = nvm_addr;
      next_data_hold = data_hold;
      next_dir_store = dir_store;
      next_busy      = busy;
      next_op_apply  = 1'b0;
      step           = 1'b0;
      finish         = 1'b0;
      case (state)
         S_IDLE: begin
            if (store_req || load_req) begin
               next_dir_store = store_req;
               next_busy      = 1'b1;
               next_seg_ptr   = `BYTE_ZERO;
               next_nvm_addr  = '0;
               next_state     = S_CMD;
            end
         end
         S_CMD: begin
            if (!seg_byte[`CMD_OP_BIT]) begin
               // a header that would run off the segment ends the walk
               if (seg_ptr >= `HDR_LIMIT) begin
                  finish = 1'b1;
               end else begin
                  next_xfer_left = seg_byte[`LEN_W-1:0];
                  next_seg_ptr   = seg_ptr + `PTR_ONE;
                  next_state     = S_ADDR_HI;
               end
            end else if (seg_byte == `OP_END) begin
               finish = 1'b1;
            end else begin
               // unknown opcodes are skipped
               next_op_apply = (seg_byte == `OP_APPLY);
               next_seg_ptr  = seg_ptr + `PTR_ONE;
               finish        = (seg_ptr == `PTR_LAST);
            end
         end
         S_ADDR_HI: begin
            next_buf_addr[11:8] = seg_byte[3:0];
            next_seg_ptr        = seg_ptr + `PTR_ONE;
            next_state          = S_ADDR_LO;
         end
         S_ADDR_LO: begin
            next_buf_addr[7:0] = seg_byte;
            next_seg_ptr       = seg_ptr + `PTR_ONE;
            next_state         = dir_store ? S_BUF_RD : S_NVM;
         end
         S_BUF_RD: begin
            next_data_hold = buf_rdata;
            next_state     = S_NVM;
         end
         S_NVM: begin
            if (nvm_ack) begin
               if (dir_store) begin
                  step = 1'b1;
               end else begin
                  next_data_hold = nvm_rdata;
                  next_state     = S_BUF_WR;
               end
            end
         end
         S_BUF_WR: begin
            step = 1'b1;
         end
         default: begin
            next_state = S_IDLE;
            next_busy  = 1'b0;
         end
      endcase
      if (step) begin
         next_buf_addr = buf_addr + `ADDR_ONE;
         next_nvm_addr = nvm_addr + `ADDR_ONE;
         if (xfer_left == `LEN_ZERO) begin
            next_state = S_CMD;
         end else begin
            next_xfer_left = xfer_left - `LEN_ONE;
            next_state     = dir_store ? S_BUF_RD : S_NVM;
         end
      end
      if (finish) begin
         next_busy  = 1'b0;
         next_state = S_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state     <= S_IDLE;
         seg_ptr   <= `BYTE_ZERO;
         xfer_left <= `LEN_ZERO;
         buf_addr  <= '0;
         nvm_addr  <= '0;
         data_hold <= `BYTE_ZERO;
         dir_store <= 1'b0;
         busy      <= 1'b0;
         op_apply  <= 1'b0;
      end else begin
         state     <= next_state;
         seg_ptr   <= next_seg_ptr;
         xfer_left <= next_xfer_left;
         buf_addr  <= next_buf_addr;
         nvm_addr  <= next_nvm_addr;
         data_hold <= next_data_hold;
         dir_store <= next_dir_store;
         busy      <= next_busy;
         op_apply  <= next_op_apply;
      end
   end

   // ==========================================================
   // outputs
   assign apply_shadow   = update_pending | op_apply;
   assign nvm_busy       = busy;
   assign buf_port.wr    = (state == S_BUF_WR);
   assign buf_port.addr  = buf_addr;
   assign buf_port.wdata = data_hold;
   assign nvm_port.req   = (state == S_NVM);
   assign nvm_port.store = dir_store;
   assign nvm_port.addr  = nvm_addr;
   assign nvm_port.wdata = data_hold;

   align_control u_align (
      .clk                 (clk),
      .sys_rst             (sys_rst),
      .ctrl                (align_ctrl),
      .runt_suppress_en    (runt_suppress_en),
      .align_power_down    (align_power_down),
      .dist_ref_power_down (dist_ref_power_down),
      .align_hold          (align_hold),
      .align_event         (align_event)
   );

endmodule

//--- inc/shadow_nvm_regs.svh
// register offsets, field positions and constants of the shadow update and nvm sequencer
// How it works
// - alignment control bit 3 low enables run-pulse suppression; high disables it.
// - alignment control bit 2 high powers down the output alignment circuitry.
// - alignment control bit 1 high powers down the distribution reference.
// - soft alignment bit high holds channels static; falling edge fires an alignment event.
// - writing 1 to update bit 0 copies buffer to active on the next clock edge.
// - the update request bit clears itself after the copy.
// - command segment at 0xA00-0xAFF lists ranges to save or restore.
// - command byte with bit 7 clear is a data transfer; set is an opcode.
// - low seven bits of a transfer command hold length minus one.
// - two bytes after a transfer command give the start address, high byte first.
// - opcodes with bit 7 set decode as apply-shadow or end-of-data; any other opcode is skipped.
// - apply-shadow opcode copies buffer to active like writing 0x01 to update.
// - end-of-data opcode stops the walk and ends the save or restore.
// - default segment moves buffer addresses 0x000-0x27F in five 128-byte chunks then issues apply-shadow.
// - store request bit starts a buffer-to-nvm save and clears itself when done.
// - read-only status bit reads 1 while a save or load runs, else 0.
`ifndef SHADOW_NVM_REGS_SVH
`define SHADOW_NVM_REGS_SVH

// ==========================================================
// widths
`define ADDR_W          12
`define DATA_W          8
`define SEG_AW          8
`define SEG_DEPTH       256
`define LEN_W           7

// ==========================================================
// register offsets
`define OFF_ALIGN_CTRL  12'h230
`define OFF_UPDATE      12'h232
`define OFF_SEG_BASE    12'hA00
`define OFF_SEG_LAST    12'hAFF
`define OFF_NVM_STATUS  12'hB00
`define OFF_NVM_LOAD    12'hB02
`define OFF_NVM_STORE   12'hB03

// ==========================================================
// field positions and values
`define BIT_REQ         0
`define BIT_LOAD        1
`define CMD_OP_BIT      7
`define ALIGN_CTRL_RST  4'h0
`define BYTE_ZERO       8'h00
`define ADDR_ONE        12'h001
`define PTR_ONE         8'h01
`define PTR_LAST        8'hFF
`define HDR_LIMIT       8'hFD
`define LEN_ZERO        7'h00
`define LEN_ONE         7'h01

// ==========================================================
// opcodes
`define OP_APPLY        8'hA0
`define OP_END          8'hFF

// ==========================================================
// default segment: contiguous chunks, then apply, then end
`define SEG_DEF_LEN     8'h7F
`define SEG_DEF_CHUNKS  5
`define SEG_DEF_STEP    12'h080

`endif

//--- inc/shadow_nvm_pkg.sv
// types shared by the shadow update and nvm sequencer
`include "shadow_nvm_regs.svh"
package shadow_nvm_pkg;

   typedef struct packed {
      logic                 wr;
      logic                 rd;
      logic [`ADDR_W-1:0]   addr;
      logic [`DATA_W-1:0]   wdata;
   } reg_req_t;

   typedef struct packed {
      logic                 wr;
      logic [`ADDR_W-1:0]   addr;
      logic [`DATA_W-1:0]   wdata;
   } buf_port_t;

   typedef struct packed {
      logic                 req;
      logic                 store;
      logic [`ADDR_W-1:0]   addr;
      logic [`DATA_W-1:0]   wdata;
   } nvm_port_t;

   typedef struct packed {
      logic no_runt;
      logic align_pd;
      logic dref_pd;
      logic soft_align;
   } align_ctrl_t;

   typedef enum logic [6:0] {
      S_IDLE    = 7'b0000001,
      S_CMD     = 7'b0000010,
      S_ADDR_HI = 7'b0000100,
      S_ADDR_LO = 7'b0001000,
      S_BUF_RD  = 7'b0010000,
      S_NVM     = 7'b0100000,
      S_BUF_WR  = 7'b1000000
   } walk_state_t;

endpackage

//--- rtl/align_control.sv
// alignment control outputs and soft alignment event detection
`timescale 1ns/1ps
`include "shadow_nvm_regs.svh"
module align_control
   import shadow_nvm_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire align_ctrl_t  ctrl,
   output logic              runt_suppress_en,
   output logic              align_power_down,
   output logic              dist_ref_power_down,
   output logic              align_hold,
   output logic              align_event
);

   // ==========================================================
   // state
   align_ctrl_t  held;
   logic         event_q;
   align_ctrl_t  next_held;
   logic         next_event_q;

   always_comb begin
      next_held    = ctrl;
      // release of the hold fires one event
      next_event_q = held.soft_align & ~ctrl.soft_align;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         held    <= align_ctrl_t'(`ALIGN_CTRL_RST);
         event_q <= 1'b0;
      end else begin
         held    <= next_held;
         event_q <= next_event_q;
      end
   end

   // ==========================================================
   // outputs
   assign runt_suppress_en    = ~held.no_runt;
   assign align_power_down    = held.align_pd;
   assign dist_ref_power_down = held.dref_pd;
   assign align_hold          = held.soft_align;
   assign align_event         = event_q;

endmodule

//--- test/shadow_nvm_sva.sv
// assertions on the ports of the shadow update and nvm sequencer
`timescale 1ns/1ps
`include "shadow_nvm_regs.svh"
module shadow_nvm_sva
   import shadow_nvm_pkg::*;
(
   input wire logic      clk,
   input wire logic      sys_rst,
   input wire reg_req_t  reg_req,
   input wire buf_port_t buf_port,
   input wire nvm_port_t nvm_port,
   input wire logic      nvm_ack,
   input wire logic [`DATA_W-1:0] nvm_rdata,
   input wire logic      apply_shadow,
   input wire logic      nvm_busy,
   input wire logic      runt_suppress_en,
   input wire logic      align_power_down,
   input wire logic      dist_ref_power_down,
   input wire logic      align_hold,
   input wire logic      align_event
);
   // ==========
   // helpers
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic ctl_wr;
   logic upd_wr;
   logic upd_q;
   assign ctl_wr = reg_req.wr && reg_req.addr == `OFF_ALIGN_CTRL;
   assign upd_wr = reg_req.wr && reg_req.addr == `OFF_UPDATE && reg_req.wdata[0];
   always_ff @(posedge clk) begin
      upd_q <= sys_rst ? 1'h0 : upd_wr;
   end
   // ==========
   // assertions
   a_runt_follow: assert property (ctl_wr |-> ##2
      runt_suppress_en == !$past(reg_req.wdata[3], 2)) else $error("runt suppress wrong");
   a_pd_follow: assert property (ctl_wr |-> ##2
      {align_power_down, dist_ref_power_down} == $past(reg_req.wdata[2:1], 2))
      else $error("power down wrong");
   a_hold_follow: assert property (ctl_wr |-> ##2
      align_hold == $past(reg_req.wdata[0], 2)) else $error("hold wrong");
   a_event_fall: assert property ($fell(align_hold) |-> align_event)
      else $error("no event on falling hold");
   a_event_pulse: assert property (align_event |=> !align_event)
      else $error("event too long");
   a_update_apply: assert property (upd_wr |=> apply_shadow)
      else $error("no apply after update");
   a_apply_cause: assert property (apply_shadow && !nvm_busy |-> upd_q)
      else $error("apply without cause");
   a_store_start: assert property (reg_req.wr && reg_req.addr == `OFF_NVM_STORE
      && reg_req.wdata[0] && !nvm_busy |-> ##[1:4] nvm_busy) else $error("store not started");
   a_req_hold: assert property (nvm_port.req && !nvm_ack |=> nvm_port.req
      && $stable(nvm_port.addr) && $stable(nvm_port.wdata)) else $error("nvm request moved");
   a_idle_noreq: assert property (!nvm_busy |-> !nvm_port.req)
      else $error("request while idle");
   a_load_copy: assert property (nvm_port.req && nvm_ack && !nvm_port.store |=>
      buf_port.wr && buf_port.wdata == $past(nvm_rdata)) else $error("load byte lost");
   c_walk_apply: cover property (apply_shadow && nvm_busy);
   c_event: cover property (align_event);
   c_load: cover property (nvm_ack && !nvm_port.store);
endmodule

//--- test/nvm_buf_model.sv
// buffer register bank and nvm array facing the sequencer
`timescale 1ns/1ps
`include "shadow_nvm_regs.svh"
module nvm_buf_model
   import shadow_nvm_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              slow,
   input  wire buf_port_t         buf_port,
   output logic [`DATA_W-1:0]     buf_rdata,
   input  wire nvm_port_t         nvm_port,
   output logic                   nvm_ack,
   output logic [`DATA_W-1:0]     nvm_rdata
);
   logic [`DATA_W-1:0] bank [0:4095];
   logic [`DATA_W-1:0] nvm  [0:4095];
   logic [1:0]         wait_cnt;
   initial begin
      for (int i = 0; i < 4096; i++) begin
         bank[i] = i[7:0] ^ 8'h5A;
         nvm[i]  = 8'h00;
      end
      nvm_ack   = 1'h0;
      nvm_rdata = 8'h00;
      wait_cnt  = 2'h0;
   end
   assign buf_rdata = bank[buf_port.addr];
   always @(posedge clk) begin
      if (buf_port.wr) begin
         bank[buf_port.addr] <= buf_port.wdata;
      end
      nvm_ack   <= 1'h0;
      // outside an answer the data line must not look valid
      nvm_rdata <= ~nvm_rdata;
      if (nvm_port.req && !nvm_ack) begin
         if (!slow || wait_cnt == 2'h3) begin
            nvm_ack   <= 1'h1;
            wait_cnt  <= 2'h0;
            nvm_rdata <= nvm[nvm_port.addr];
            if (nvm_port.store) begin
               nvm[nvm_port.addr] <= nvm_port.wdata;
            end
         end else begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule

//--- test/tb_shadow_update_nvm_sequencer.sv
// self-checking bench for the shadow update and nvm sequencer
`timescale 1ns/1ps
`include "shadow_nvm_regs.svh"
module tb_shadow_update_nvm_sequencer
   import shadow_nvm_pkg::*;
;
   logic              clk = 1'h0;
   logic              sys_rst = 1'h1;
   logic              slow = 1'h0;
   reg_req_t          reg_req = '0;
   logic [7:0]        reg_rdata, buf_rdata, nvm_rdata, rd_val;
   buf_port_t         buf_port;
   nvm_port_t         nvm_port;
   logic              nvm_ack, apply_shadow, nvm_busy, ap_seen;
   logic              runt_suppress_en, align_power_down, dist_ref_power_down;
   logic              align_hold, align_event;
   int                miscompares = 0, cmp_count = 0, cycles = 0;
   int                applies = 0, acks = 0, a0, k0;
   logic [7:0]        ctl [5] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h00};
   logic [7:0]        seg_a [5] = '{8'h01, 8'h01, 8'h23, `OP_APPLY, `OP_END};
   logic [7:0]        seg_b [8] = '{8'h00, 8'h0F, 8'hF0, 8'h81, 8'h00, 8'h01, 8'h00, `OP_END};
   always #2.5 clk = ~clk;
   shadow_update_nvm_sequencer DUT (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .buf_rdata(buf_rdata), .buf_port(buf_port), .nvm_port(nvm_port),
      .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .apply_shadow(apply_shadow),
      .nvm_busy(nvm_busy), .runt_suppress_en(runt_suppress_en),
      .align_power_down(align_power_down), .dist_ref_power_down(dist_ref_power_down),
      .align_hold(align_hold), .align_event(align_event));
   nvm_buf_model u_nvm (.clk(clk), .slow(slow), .buf_port(buf_port), .buf_rdata(buf_rdata),
      .nvm_port(nvm_port), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata));
   // ==========
   // tasks
   function automatic logic [7:0] pat(input logic [11:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic access(input logic w, input logic [11:0] a, input logic [7:0] d);
      reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk);
      reg_req <= '0;
      @(posedge clk);
      ap_seen = apply_shadow;
      rd_val  = reg_rdata;
   endtask
   task automatic wait_idle();
      repeat (3) @(posedge clk);
      for (int i = 0; i < 5000 && nvm_busy !== 1'h0; i++) @(posedge clk);
      repeat (2000) @(posedge clk); // 10 us host gap
   endtask
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========
   // monitors and timeout
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (apply_shadow === 1'h1) applies <= applies + 1;
      if (nvm_ack === 1'h1 && nvm_port.req === 1'h1) acks <= acks + 1;
      if (cycles == 50000) begin
         miscompares++;
         complete_run();
      end
   end
   // ==========
   // tests
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      chk("ctrl at reset", 16'h10, 16'({runt_suppress_en, align_power_down,
         dist_ref_power_down, align_hold, align_event}));
      // last entry clears hold after it was set, so the event must fire there
      foreach (ctl[i]) begin
         access(1'h1, `OFF_ALIGN_CTRL, ctl[i]);
         @(posedge clk);
         chk("ctrl outputs", 16'({~ctl[i][3], ctl[i][2:0], i == 4}),
            16'({runt_suppress_en, align_power_down, dist_ref_power_down, align_hold,
            align_event}));
      end
      access(1'h1, `OFF_UPDATE, 8'h00);
      chk("apply on zero", 16'h0, 16'(ap_seen));
      access(1'h1, `OFF_UPDATE, 8'h01);
      chk("apply on one", 16'h1, 16'(ap_seen));
      access(1'h0, `OFF_UPDATE, 8'h00);
      chk("update bit", 16'h0, 16'(rd_val));
      access(1'h0, `OFF_SEG_BASE, 8'h00);
      chk("segment byte", 16'(`SEG_DEF_LEN), 16'(rd_val));
      access(1'h0, 12'h100, 8'h00);
      chk("unmapped read", 16'h0, 16'(rd_val));
      // store: two bytes at 0x123, apply, end; default end codes remain at the tail
      foreach (seg_a[i]) access(1'h1, `OFF_SEG_BASE + 12'(i), seg_a[i]);
      slow <= 1'h1;
      a0 = applies;
      k0 = acks;
      access(1'h1, `OFF_NVM_STORE, 8'h01);
      repeat (3) @(posedge clk);
      access(1'h0, `OFF_NVM_STATUS, 8'h00);
      chk("busy status", 16'h1, 16'(rd_val));
      wait_idle();
      access(1'h0, `OFF_NVM_STATUS, 8'h00);
      chk("idle status", 16'h0, 16'(rd_val));
      access(1'h0, `OFF_NVM_STORE, 8'h00);
      chk("store bit", 16'h0, 16'(rd_val));
      chk("nvm byte 0", 16'(pat(12'h123)), 16'(u_nvm.nvm[0]));
      chk("nvm byte 1", 16'(pat(12'h124)), 16'(u_nvm.nvm[1]));
      chk("bytes saved", 16'd2, 16'(acks - k0));
      chk("walk applies", 16'h1, 16'(applies - a0));
      // load: two one-byte entries around an unknown opcode, store refused mid-walk
      u_nvm.nvm[0] = 8'hC6;
      u_nvm.nvm[1] = 8'h39;
      foreach (seg_b[i]) access(1'h1, `OFF_SEG_BASE + 12'(i), seg_b[i]);
      slow <= 1'h0;
      a0 = applies;
      k0 = acks;
      access(1'h1, `OFF_NVM_LOAD, 8'h02);
      access(1'h1, `OFF_NVM_STORE, 8'h01);
      wait_idle();
      chk("restored 0xFF0", 16'hC6, 16'(u_nvm.bank[12'hFF0]));
      chk("restored 0x100", 16'h39, 16'(u_nvm.bank[12'h100]));
      chk("bytes loaded", 16'd2, 16'(acks - k0));
      chk("load applies", 16'h0, 16'(applies - a0));
      // second reset brings back the default segment: whole range then apply
      sys_rst <= 1'h1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      a0 = applies;
      k0 = acks;
      access(1'h1, `OFF_NVM_STORE, 8'h01);
      wait_idle();
      chk("bytes saved", 16'd640, 16'(acks - k0));
      chk("last byte", 16'(pat(12'h27F)), 16'(u_nvm.nvm[12'h27F]));
      chk("past end", 16'h0, 16'(u_nvm.nvm[12'h280]));
      chk("default applies", 16'h1, 16'(applies - a0));
      // long run of skipped opcodes, then a header too close to the end: no byte moves
      for (int i = 0; i < `SEG_DEPTH; i++) access(1'h1, `OFF_SEG_BASE + 12'(i), 8'h81);
      access(1'h1, `OFF_SEG_BASE + 12'h0FD, 8'h00);
      access(1'h1, `OFF_SEG_BASE + 12'h0FF, `OP_END);
      k0 = acks;
      access(1'h1, `OFF_NVM_LOAD, 8'h02);
      access(1'h0, `OFF_NVM_STATUS, 8'h00);
      chk("long walk busy", 16'h1, 16'(rd_val));
      wait_idle();
      access(1'h0, `OFF_NVM_STATUS, 8'h00);
      chk("cut header status", 16'h0, 16'(rd_val));
      chk("cut header bytes", 16'd0, 16'(acks - k0));
      complete_run();
   end
endmodule

bind shadow_update_nvm_sequencer shadow_nvm_sva u_sva (.clk(clk), .sys_rst(sys_rst),
   .reg_req(reg_req), .buf_port(buf_port), .nvm_port(nvm_port), .nvm_ack(nvm_ack),
   .nvm_rdata(nvm_rdata), .apply_shadow(apply_shadow), .nvm_busy(nvm_busy),
   .runt_suppress_en(runt_suppress_en), .align_power_down(align_power_down),
   .dist_ref_power_down(dist_ref_power_down), .align_hold(align_hold),
   .align_event(align_event));
